/* File: design/csd_host.sv */
// board controller: drives the straps and sends serial register frames
`timescale 1ns/10ps
`default_nettype none
module csd_host #(
  parameter int HALF_DIV = csd_pkg::HALF_DIV,
  parameter int GAP_PERIODS = csd_pkg::GAP_PERIODS
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  csd_if.host link
);
  import csd_pkg::*;

  typedef enum {CSD_IDLE, CSD_SHIFT, CSD_GAP} csd_state_t;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl;
  logic [NUM_REGS-1:0] sent_mask;
  logic refused;
  logic seq_refused;
  logic cmd_pend;
  logic [FRAME_BITS-1:0] cmd_word;
  csd_state_t state;

  wire hit_ctrl = (paddr == OFS_CTRL);
  wire hit_cmd = (paddr == OFS_CMD);
  wire hit_status = (paddr == OFS_STATUS);
  wire mapped = hit_ctrl || hit_cmd || hit_status;
  wire access = psel && penable;
  wire wr_ctrl = access && pwrite && hit_ctrl;
  wire wr_cmd = access && pwrite && hit_cmd;
  wire busy = cmd_pend || (state != CSD_IDLE);
  wire all_sent = &sent_mask;
  wire [31:0] status_word = {16'h0000, sent_mask,
                             4'h0, seq_refused, refused, all_sent, busy};

  // zero wait states; unmapped addresses answer with an error
  assign pready = access;
  assign pslverr = access && !mapped;

  // read data settles during the setup cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= hit_ctrl ? {25'h0000000, ctrl} :
                hit_status ? status_word : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // command screening
  // ----------------------------------------------------------------
  wire [ADDR_W-1:0] c_addr = pwdata[FRAME_BITS-1:DATA_W];
  wire [DATA_W-1:0] c_data = pwdata[DATA_W-1:0];
  logic [NUM_REGS-1:0] c_hit;
  genvar gh;
  generate
    for (gh = 0; gh < NUM_REGS; gh++) begin : g_hit
      assign c_hit[gh] = (c_addr == REG_ADDR[gh]);
    end
  endgenerate
  wire c_des = c_hit[DES_IDX];
  // first dual-edge write must carry the default
  wire c_bad_first = c_des && !sent_mask[DES_IDX] &&
                     (c_data != DES_DEFAULT);
  // enabling waits until every register has had its first write
  wire c_bad_early = c_des && !all_sent && c_data[DES_EN_BIT];
  wire c_seq_bad = c_bad_first || c_bad_early;
  wire c_refuse = busy || !ctrl[CTRL_SERIAL] || (c_hit == '0);
  wire c_take = wr_cmd && !c_refuse && !c_seq_bad;

  // control word, and the record of registers already written
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl <= CTRL_RESET;
      sent_mask <= '0;
      refused <= 1'b0;
      seq_refused <= 1'b0;
    end else begin
      if (wr_ctrl && !busy) begin
        ctrl <= pwdata[CTRL_W-1:0];
      end
      if (wr_cmd) begin
        refused <= c_refuse;
        seq_refused <= !c_refuse && c_seq_bad;
      end
      if (c_take) begin
        sent_mask <= sent_mask | c_hit;
      end
    end
  end

  // ----------------------------------------------------------------
  // serial clock divider and frame engine
  // ----------------------------------------------------------------
  logic [7:0] div_cnt;
  logic sclk;
  logic serial_line_data;
  logic sel_n;
  logic [FRAME_BITS-1:0] shreg;
  logic [4:0] bit_cnt;
  logic [3:0] gap_cnt;
  wire tick = (div_cnt == 8'(HALF_DIV - 1));
  // data changes on the falling edge, the device samples on rising
  wire fall = tick && sclk;

  // clock runs free in serial mode so the far side keeps its edges
  always_ff @(posedge clk_sys) begin
    if (reset || !ctrl[CTRL_SERIAL]) begin
      div_cnt <= 8'h00;
      sclk <= 1'b0;
    end else begin
      div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
      sclk <= tick ? !sclk : sclk;
    end
  end

  // pending command is held until the engine takes it
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cmd_pend <= 1'b0;
      cmd_word <= '0;
    end else if (c_take) begin
      cmd_pend <= 1'b1;
      cmd_word <= pwdata[FRAME_BITS-1:0];
    end else if (fall && state == CSD_IDLE) begin
      cmd_pend <= 1'b0;
    end
  end

  // frame: select low, twenty bits msb first, then select high gap
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= CSD_IDLE;
      sel_n <= 1'b1;
      serial_line_data <= 1'b0;
      shreg <= '0;
      bit_cnt <= 5'h00;
      gap_cnt <= 4'h0;
    end else if (fall) begin
      case (state)
        CSD_IDLE: begin
          if (cmd_pend) begin
            sel_n <= 1'b0;
            serial_line_data <= cmd_word[FRAME_BITS-1];
            shreg <= {cmd_word[FRAME_BITS-2:0], 1'b0};
            bit_cnt <= 5'h01;
            state <= CSD_SHIFT;
          end
        end
        CSD_SHIFT: begin
          if (bit_cnt == FRAME_DONE) begin
            sel_n <= 1'b1;
            gap_cnt <= 4'h0;
            state <= CSD_GAP;
          end else begin
            serial_line_data <= shreg[FRAME_BITS-1];
            shreg <= {shreg[FRAME_BITS-2:0], 1'b0};
            bit_cnt <= bit_cnt + 5'h01;
          end
        end
        CSD_GAP: begin
          gap_cnt <= gap_cnt + 4'h1;
          if (gap_cnt == 4'(GAP_PERIODS - 1)) begin
            state <= CSD_IDLE;
          end
        end
        default: state <= CSD_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // strap drive
  // ----------------------------------------------------------------
  wire ser = ctrl[CTRL_SERIAL];
  wire [1:0] edge_code = ctrl[CTRL_EDGE_LSB +: 2];
  wire [1:0] cal_code = ctrl[CTRL_CAL_LSB +: 2];

  // serial mode repurposes three straps and floats the mode strap
  assign link.strap_out[STRAP_SWING] = ser ? sclk :
                                      ctrl[CTRL_SWING_HI];
  assign link.strap_oe[STRAP_SWING] = 1'b1;
  assign link.strap_out[STRAP_EDGE] = ser ? serial_line_data :
                                     (edge_code == DRV_HIGH);
  assign link.strap_oe[STRAP_EDGE] = ser || (edge_code != DRV_FLOAT);
  assign link.strap_out[STRAP_CAL] = ser ? sel_n :
                                    (cal_code == DRV_HIGH);
  assign link.strap_oe[STRAP_CAL] = ser || (cal_code != DRV_FLOAT);
  assign link.strap_out[STRAP_MODE] = ctrl[CTRL_MODE_HI];
  assign link.strap_oe[STRAP_MODE] = !ser;

endmodule
`default_nettype wire

/* File: design/csd_pkg.sv */
// constants and types shared by the strap decode device and its controller
package csd_pkg;

  // ----------------------------------------------------------------
  // strap pins, by position in the strap bundle
  // ----------------------------------------------------------------
  localparam int NUM_STRAPS = 4;
  localparam int STRAP_SWING = 0; // output swing, serial clock in serial mode
  localparam int STRAP_EDGE = 1; // output edge, serial data in serial mode
  localparam int STRAP_CAL = 2; // calibration delay, select in serial mode
  localparam int STRAP_MODE = 3; // pin mode when driven, serial when floating

  // three-level reading of one strap
  typedef enum logic [1:0] {
    CSD_ST_LOW,
    CSD_ST_HIGH,
    CSD_ST_FLOAT
  } csd_strap_t;

  // controller drive codes for a three-level strap
  localparam logic [1:0] DRV_LOW = 2'h0;
  localparam logic [1:0] DRV_HIGH = 2'h1;
  localparam logic [1:0] DRV_FLOAT = 2'h2;

  // ----------------------------------------------------------------
  // serial frame: address then data, msb first
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int FRAME_BITS = ADDR_W + DATA_W;
  localparam logic [4:0] FRAME_LAST = 5'h13;
  localparam logic [4:0] FRAME_DONE = 5'h14;

  // ----------------------------------------------------------------
  // device user registers
  // ----------------------------------------------------------------
  localparam int NUM_REGS = 8;
  localparam int DES_IDX = 6;
  localparam logic [3:0] DES_ADDR = 4'hD;
  localparam logic [15:0] DES_DEFAULT = 16'h3FFF;
  localparam int DES_EN_BIT = 15;
  localparam logic [3:0] REG_ADDR [NUM_REGS] = '{
    4'h1, 4'h2, 4'h3, 4'h9, 4'hA, 4'hB, DES_ADDR, 4'hE
  };
  localparam logic [15:0] REG_RESET [NUM_REGS] = '{
    16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, DES_DEFAULT, 16'h0000
  };

  // ----------------------------------------------------------------
  // controller apb registers
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam int CTRL_SERIAL = 0;
  localparam int CTRL_SWING_HI = 1;
  localparam int CTRL_EDGE_LSB = 2;
  localparam int CTRL_CAL_LSB = 4;
  localparam int CTRL_MODE_HI = 6;
  localparam int CTRL_W = 7;
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam int ST_BUSY = 0;
  localparam int ST_ALL_WRITTEN = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_SEQ_REFUSED = 3;
  localparam int ST_MASK_LSB = 8;

  // ----------------------------------------------------------------
  // link timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_MHZ = 50;
  localparam int LINK_PERIOD_NS = 160;
  localparam int HALF_DIV = LINK_PERIOD_NS * SYS_CLK_MHZ / 2000;
  localparam int GAP_PERIODS = 2;

endpackage

/* File: design/csd_if.sv */
// strap and serial pins between the controller and the device
`timescale 1ns/10ps
`default_nettype none
interface csd_if;
  import csd_pkg::*;

  logic [NUM_STRAPS-1:0] strap_out;
  logic [NUM_STRAPS-1:0] strap_oe;
  logic [NUM_STRAPS-1:0] strap_lvl;
  logic [NUM_STRAPS-1:0] strap_drv;
  logic lk_clk;

  // pin level seen by the device; an undriven strap rests low
  assign strap_lvl = strap_out & strap_oe;
  // tri-level sensing: does anyone drive the strap
  assign strap_drv = strap_oe;
  // serial clock rides on the swing strap
  assign lk_clk = strap_out[STRAP_SWING] & strap_oe[STRAP_SWING];

  modport host (output strap_out, output strap_oe);
  modport device (input strap_lvl, input strap_drv, input lk_clk);
endinterface
`default_nettype wire

/* File: design/csd_device.sv */
// strap decode and serial register file of the converter control logic
`timescale 1ns/10ps
`default_nettype none

// Operation
// - driven mode strap: pins; floating: serial
// - edge strap low/high: negative/positive output edge
// - floating edge strap: double data rate
// - cal strap low/high: short/long delay
// - floating cal strap: short delay, dual-edge sampling
// - serial mode: straps become clock, data, select
// - host writes all eight registers first
// - first dual-edge register write loads default
// - other settings only after all first writes
module csd_device #(
  parameter int NUM_REGS = csd_pkg::NUM_REGS
) (
  input wire logic clk_sys,
  input wire logic reset,
  csd_if.device link,
  input wire logic [csd_pkg::ADDR_W-1:0] rd_addr,
  output logic [csd_pkg::DATA_W-1:0] rd_data,
  output logic mode_serial,
  output logic output_swing_high,
  output logic output_edge_pos,
  output logic ddr_mode,
  output logic cal_delay_long,
  output logic des_active,
  output logic all_written,
  output logic seq_error
);
  import csd_pkg::*;

  // ----------------------------------------------------------------
  // strap sensing
  // ----------------------------------------------------------------
  logic [NUM_STRAPS-1:0] lvl_meta;
  logic [NUM_STRAPS-1:0] lvl_sync;
  logic [NUM_STRAPS-1:0] drv_meta;
  logic [NUM_STRAPS-1:0] drv_sync;
  csd_strap_t strap_state [NUM_STRAPS];

  // straps are board pins: two flops before any decode
  always_ff @(posedge clk_sys) begin
    lvl_meta <= link.strap_lvl;
    lvl_sync <= lvl_meta;
    drv_meta <= link.strap_drv;
    drv_sync <= drv_meta;
  end

  // three-level reading per strap
  genvar gs;
  generate
    for (gs = 0; gs < NUM_STRAPS; gs++) begin : g_strap
      assign strap_state[gs] = !drv_sync[gs] ? CSD_ST_FLOAT :
                               lvl_sync[gs] ? CSD_ST_HIGH :
                               CSD_ST_LOW;
    end
  endgenerate

  // ----------------------------------------------------------------
  // serial receiver on the link clock
  // ----------------------------------------------------------------
  logic lk_rst_meta;
  logic lk_rst;
  logic [FRAME_BITS-1:0] lk_shift;
  logic [4:0] lk_cnt;
  logic lk_done;
  wire lk_sel_n = link.strap_lvl[STRAP_CAL];
  wire lk_serial_line_data = link.strap_lvl[STRAP_EDGE];

  // reset arrives from the system domain
  always_ff @(posedge link.lk_clk) begin
    lk_rst_meta <= reset;
    lk_rst <= lk_rst_meta;
  end

  // shift one frame while select is low; later bits are ignored
  always_ff @(posedge link.lk_clk) begin
    if (lk_rst || lk_sel_n) begin
      lk_cnt <= 5'h00;
      lk_done <= 1'b0;
    end else if (!lk_done) begin
      lk_shift <= {lk_shift[FRAME_BITS-2:0], lk_serial_line_data};
      lk_cnt <= lk_cnt + 5'h01;
      lk_done <= (lk_cnt == FRAME_LAST);
    end
  end

  // ----------------------------------------------------------------
  // frame hand-over to the system domain
  // ----------------------------------------------------------------
  logic done_meta;
  logic done_sync;
  logic done_prev;

  // done is a level held until select rises, so the word is stable
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      done_meta <= 1'b0;
      done_sync <= 1'b0;
      done_prev <= 1'b0;
    end else begin
      done_meta <= lk_done;
      done_sync <= done_meta;
      done_prev <= done_sync;
    end
  end

  wire frame_go = mode_serial && done_sync && !done_prev;
  wire [ADDR_W-1:0] wr_addr = lk_shift[FRAME_BITS-1:DATA_W];
  wire [DATA_W-1:0] wr_data = lk_shift[DATA_W-1:0];

  // ----------------------------------------------------------------
  // user register file
  // ----------------------------------------------------------------
  logic [NUM_REGS-1:0][DATA_W-1:0] regs;
  logic [NUM_REGS-1:0] written;
  logic [NUM_REGS-1:0] wr_hit;
  logic [NUM_REGS-1:0] rd_hit;
  logic [DATA_W-1:0] next_rd_data;

  // address match per register
  genvar gr;
  generate
    for (gr = 0; gr < NUM_REGS; gr++) begin : g_reg
      assign wr_hit[gr] = frame_go && (wr_addr == REG_ADDR[gr]);
      assign rd_hit[gr] = (rd_addr == REG_ADDR[gr]);
    end
  endgenerate

  // store a frame and mark the register as written once
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= REG_RESET[i];
      end
      written <= '0;
    end else begin
      for (int i = 0; i < NUM_REGS; i++) begin
        if (wr_hit[i]) begin
          regs[i] <= wr_data;
          written[i] <= 1'b1;
        end
      end
    end
  end

  // read mux; unknown addresses read zero
  always_comb begin
    next_rd_data = '0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (rd_hit[i]) begin
        next_rd_data = regs[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // start-up order check
  // ----------------------------------------------------------------
  wire all_done = &written;
  wire des_hit = wr_hit[DES_IDX];
  // first dual-edge write not the default value
  wire bad_first = des_hit && !written[DES_IDX] &&
                   (wr_data != DES_DEFAULT);
  // sampling enabled before every register saw its first write
  wire bad_early = des_hit && !all_done &&
                   wr_data[DES_EN_BIT];

  // sticky until reset; the device only reports, never refuses
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      seq_error <= 1'b0;
    end else if (bad_first || bad_early) begin
      seq_error <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  wire next_serial = (strap_state[STRAP_MODE] == CSD_ST_FLOAT);
  wire pin_mode = !next_serial;
  wire next_swing = pin_mode &&
                    (strap_state[STRAP_SWING] == CSD_ST_HIGH);
  wire next_ddr = pin_mode &&
                  (strap_state[STRAP_EDGE] == CSD_ST_FLOAT);
  // edge choice is meaningless once data leaves on both edges
  wire next_edge_pos = pin_mode &&
                       (strap_state[STRAP_EDGE] == CSD_ST_HIGH);
  // floating cal strap keeps the short delay like low
  wire next_cal_long = pin_mode &&
                       (strap_state[STRAP_CAL] == CSD_ST_HIGH);
  wire pin_des = pin_mode &&
                 (strap_state[STRAP_CAL] == CSD_ST_FLOAT);
  // serial mode: sampling follows the register, only once armed
  wire ser_des = next_serial && all_done &&
                 regs[DES_IDX][DES_EN_BIT];
  wire next_des = pin_des || ser_des;

  // all decoded settings leave from flops
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_serial <= 1'b0;
      output_swing_high <= 1'b0;
      output_edge_pos <= 1'b0;
      ddr_mode <= 1'b0;
      cal_delay_long <= 1'b0;
      des_active <= 1'b0;
      all_written <= 1'b0;
      rd_data <= '0;
    end else begin
      mode_serial <= next_serial;
      output_swing_high <= next_swing;
      output_edge_pos <= next_edge_pos;
      ddr_mode <= next_ddr;
      cal_delay_long <= next_cal_long;
      des_active <= next_des;
      all_written <= all_done;
      rd_data <= next_rd_data;
    end
  end

endmodule
`default_nettype wire

/* File: tb/csd_link_monitor.sv */
// link checker: strap drive and serial framing seen on the interface pins
`timescale 1ns/10ps
`default_nettype none
module csd_link_monitor (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [csd_pkg::NUM_STRAPS-1:0] strap_out,
  input wire logic [csd_pkg::NUM_STRAPS-1:0] strap_oe,
  input wire logic [csd_pkg::NUM_STRAPS-1:0] strap_lvl,
  input wire logic [csd_pkg::NUM_STRAPS-1:0] strap_drv,
  input wire logic lk_clk
);
  import csd_pkg::*;

  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic serial_on;
  logic sel;
  logic lk_q;
  logic lk_rise;
  logic [8:0] sel_low;
  logic [5:0] bit_cnt;

  // mode strap floats in serial mode; select rides on the cal strap
  assign serial_on = !strap_oe[STRAP_MODE];
  assign sel = strap_out[STRAP_CAL];
  assign lk_rise = lk_clk & !lk_q;

  // select low time and sampling edges in it; cleared while select high
  always_ff @(posedge clk_sys) begin
    lk_q <= lk_clk;
    if (reset || sel) begin
      sel_low <= 9'h000;
      bit_cnt <= 6'h00;
    end else if (serial_on) begin
      sel_low <= sel_low + 9'h001;
      bit_cnt <= bit_cnt + {5'h00, lk_rise};
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking mon_cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  a_mode_after_reset: assert property (
    $fell(reset) |-> strap_oe[STRAP_MODE] && !strap_out[STRAP_MODE])
    else $error("mode strap not driven low after reset");
  a_data_on_low: assert property (
    $changed(strap_out[STRAP_EDGE]) && serial_on |-> !lk_clk)
    else $error("serial data changed while serial clock high");
  a_serial_drives: assert property (
    serial_on |-> &strap_oe[STRAP_CAL:STRAP_SWING])
    else $error("serial strap left undriven in serial mode");
  // select spans exactly one serial clock period per frame bit
  a_frame_length: assert property (
    $rose(sel) && serial_on |-> sel_low == 9'(FRAME_BITS * 2 * HALF_DIV))
    else $error("select low time wrong");
  a_frame_bits: assert property (
    $rose(sel) && serial_on |-> bit_cnt == 6'h14)
    else $error("frame does not hold twenty clock edges");
  a_frame_gap: assert property (
    $rose(sel) && serial_on |-> sel[*8] ##1 sel[*7])
    else $error("gap between frames too short");
  a_data_steady: assert property (
    lk_rise && serial_on && !sel |-> $stable(strap_out[STRAP_EDGE]))
    else $error("serial data moved at the sampling edge");
  a_clock_shape: assert property (
    $rose(lk_clk) && serial_on |-> lk_clk[*4] ##1 !lk_clk[*4])
    else $error("serial clock half period wrong");
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench: controller and strap decoder joined by the link
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
  bad_count++; $display("mismatch t=%0t got %h exp %h", $time, got, exp); \
  end end
module testbench;
  import csd_pkg::*;

  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, errv, s, m;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv, r;
  logic [3:0] rd_addr;
  logic [15:0] rd_data;
  logic [15:0] mem [16];
  logic mode_serial, output_swing_high, output_edge_pos, ddr_mode;
  logic cal_delay_long, des_active, all_written, seq_error;
  int bad_count = 0;
  int checks_done = 0;
  integer seed = 32'h0bf32e62;

  csd_if link();
  csd_host csd_host_i (.clk_sys(clk_sys), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.host));
  csd_device csd_device_i (.clk_sys(clk_sys), .reset(reset),
    .link(link.device), .rd_addr(rd_addr), .rd_data(rd_data),
    .mode_serial(mode_serial), .output_swing_high(output_swing_high),
    .output_edge_pos(output_edge_pos), .ddr_mode(ddr_mode),
    .cal_delay_long(cal_delay_long), .des_active(des_active),
    .all_written(all_written), .seq_error(seq_error));
  csd_link_monitor csd_link_monitor_i (.clk_sys(clk_sys), .reset(reset),
    .strap_out(link.strap_out), .strap_oe(link.strap_oe),
    .strap_lvl(link.strap_lvl), .strap_drv(link.strap_drv),
    .lk_clk(link.lk_clk));

  // 50 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one apb transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) bad_count++;
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge: the next call must not reassign psel in this step
    @(posedge clk_sys);
  endtask

  // send one register command; ex holds the expected {seq, plain} refusals
  task automatic cmd(input logic [3:0] a, input logic [15:0] d,
                     input logic [1:0] ex);
    int n;
    apb(1'b1, OFS_CMD, {12'h000, a, d});
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rdv[ST_SEQ_REFUSED:ST_REFUSED], ex)
    n = 0;
    while (rdv[ST_BUSY] !== 1'b0 && n < 400) begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end
    if (n == 400) bad_count++;
    if (ex == 2'b00) mem[a] = d;
    repeat (10) @(posedge clk_sys);
    rd_addr <= a;
    repeat (2) @(posedge clk_sys);
    `CHK(rd_data, mem[a])
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rd_addr = 4'h0;
    foreach (mem[i]) mem[i] = 16'h0000;
    for (int i = 0; i < NUM_REGS; i++) mem[REG_ADDR[i]] = REG_RESET[i];
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    // every edge and cal code, random swing and mode level
    for (int e = 0; e < 3; e++) begin
      for (int c = 0; c < 3; c++) begin
        r = $random(seed);
        s = r[0];
        m = r[1];
        apb(1'b1, OFS_CTRL, {25'h0, m, 2'(c), 2'(e), s, 1'b0});
        repeat (8) @(posedge clk_sys);
        `CHK(mode_serial, 1'b0)
        `CHK(output_swing_high, s)
        `CHK(output_edge_pos, e == 1)
        `CHK(ddr_mode, e == 2)
        `CHK(cal_delay_long, c == 1)
        `CHK(des_active, c == 2)
        apb(1'b0, OFS_CTRL, 32'h0);
        `CHK(rdv[6:0], {m, 2'(c), 2'(e), s, 1'b0})
      end
    end
    apb(1'b0, 8'h0C, 32'h0);
    `CHK({errv, rdv}, {1'b1, 32'h0})
    cmd(4'h1, 16'hABCD, 2'b01);
    $display("test pin decode done");
    // cal strap high first so select idles high on entry
    apb(1'b1, OFS_CTRL, 32'h10);
    apb(1'b1, OFS_CTRL, 32'h11);
    repeat (8) @(posedge clk_sys);
    `CHK({mode_serial, ddr_mode, des_active}, 3'b100)
    cmd(4'h5, 16'h1234, 2'b01);
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      cmd(REG_ADDR[i], r[15:0], 2'b00);
    end
    cmd(DES_ADDR, 16'h0000, 2'b10);
    cmd(DES_ADDR, DES_DEFAULT, 2'b00);
    cmd(DES_ADDR, 16'hBFFF, 2'b10);
    `CHK({all_written, des_active}, 2'b00)
    r = $random(seed);
    cmd(REG_ADDR[7], r[15:0], 2'b00);
    `CHK(all_written, 1'b1)
    `CHK({rdv[15:8], rdv[ST_ALL_WRITTEN]}, 9'h1FF)
    cmd(DES_ADDR, 16'hBFFF, 2'b00);
    `CHK({des_active, seq_error}, 2'b10)
    for (int i = 0; i < NUM_REGS; i++) begin
      rd_addr <= REG_ADDR[i];
      repeat (2) @(posedge clk_sys);
      `CHK(rd_data, mem[REG_ADDR[i]])
    end
    $display("test serial sequence done");
    finish_test();
  end

  // cuts a hang short well after the expected run length
  initial begin
    #600000;
    bad_count++;
    finish_test();
  end
endmodule
`default_nettype wire
